// ===== design/serial_port_pins.sv
// Pin layer of two serial ports: modem lines, data, infrared, straps
//
// Contract
// - Clear-to-send level of each port readable as bit 4 of its status.
// - Each UART receives on its serial input, sends on its serial output.
// - Infrared select makes port B serial input the infrared receive input.
// - Infrared select drives port B serial output as infrared transmit.
// - Each UART drives terminal-ready low when ready to communicate.
// - Each UART drives request-to-send low when ready to send data.
// - Port A serial output pulled up at reset, sampled as UART A hi.
// - Port B terminal-ready pulled down, sampled as UART A lo select.
// - Port B serial output pulled up at reset, sampled as UART B hi.
// - Port B request-to-send pulled down, sampled as UART B lo.
// - Port A terminal-ready pulled down, sampled as printer lo select.
// - Port A request-to-send pulled up, sampled as printer hi select.
// - UART at first or third COM address uses primary line, else second.
// - Serial interrupt lines float while host enable low and after reset.
`timescale 1ns/10ps
`include "serial_pins_params.svh"

module serial_port_pins #(
	parameter int SETTLE_CYC = `STRAP_SETTLE_CYC,
	parameter int CNT_W      = 8
) (
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	// Modem control pins, active low
	input  wire logic                       clear_to_send_in_a_n_i,
	input  wire logic                       clear_to_send_in_b_n_i,
	input  wire logic                       set_ready_in_a_n_i,
	input  wire logic                       set_ready_in_b_n_i,
	input  wire logic                       carrier_detect_in_a_n_i,
	input  wire logic                       carrier_detect_in_b_n_i,
	input  wire logic                       ring_indicate_in_a_n_i,
	input  wire logic                       ring_indicate_in_b_n_i,
	// Serial data input pins
	input  wire logic                       serial_rx_a_i,
	input  wire logic                       serial_rx_b_i,
	// Shared output and strap pins
	input  wire logic                       serial_tx_a_i,
	output logic                            serial_tx_a_o,
	output logic                            serial_tx_a_oe_n_o,
	input  wire logic                       serial_tx_b_i,
	output logic                            serial_tx_b_o,
	output logic                            serial_tx_b_oe_n_o,
	input  wire logic                       terminal_ready_out_a_n_i,
	output logic                            terminal_ready_out_a_n_o,
	output logic                            terminal_ready_out_a_oe_n_o,
	input  wire logic                       terminal_ready_out_b_n_i,
	output logic                            terminal_ready_out_b_n_o,
	output logic                            terminal_ready_out_b_oe_n_o,
	input  wire logic                       request_send_out_a_n_i,
	output logic                            request_send_out_a_n_o,
	output logic                            request_send_out_a_oe_n_o,
	input  wire logic                       request_send_out_b_n_i,
	output logic                            request_send_out_b_n_o,
	output logic                            request_send_out_b_oe_n_o,
	output logic                            strap_pull_up_o,
	output logic                            strap_pull_down_o,
	// Interrupt pins toward the host
	output logic                            serial_irq_primary_o,
	output logic                            serial_irq_primary_oe_n_o,
	output logic                            serial_irq_secondary_o,
	output logic                            serial_irq_secondary_oe_n_o,
	// UART core side
	input  wire logic                       uart_tx_a_i,
	input  wire logic                       uart_tx_b_i,
	input  wire logic                       infrared_tx_i,
	input  wire logic                       terminal_ready_a_i,
	input  wire logic                       terminal_ready_b_i,
	input  wire logic                       request_send_a_i,
	input  wire logic                       request_send_b_i,
	input  wire logic                       uart_irq_a_i,
	input  wire logic                       uart_irq_b_i,
	input  wire logic                       infrared_select_i,
	input  wire logic                       host_irq_enable_i,
	input  wire logic                       status_read_a_i,
	input  wire logic                       status_read_b_i,
	output logic                            uart_rx_a_o,
	output logic                            uart_rx_b_o,
	output logic                            infrared_rx_o,
	output logic                      [7:0] handshake_status_a_o,
	output logic                      [7:0] handshake_status_b_o,
	// Latched strap results
	output logic                            straps_valid_o,
	output serial_pins_pkg::addr_sel_t      uart_a_sel_o,
	output serial_pins_pkg::addr_sel_t      uart_b_sel_o,
	output serial_pins_pkg::addr_sel_t      printer_sel_o,
	output logic                      [9:0] uart_a_base_o,
	output logic                      [9:0] uart_b_base_o,
	output logic                      [9:0] printer_base_o
);

	import serial_pins_pkg::*;

	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

	// Synchronised pin levels
	logic [7:0]  modem_n_s;
	logic [1:0]  rx_s;
	logic [5:0]  strap_s;
	logic        running;
	logic [5:0]  strap_sample;

	// Every pin from outside passes two flops before use
	pin_sync #(
		.W         (16),
		.RESET_BIT (`LINE_IDLE)
	) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.pins_i    ({request_send_out_a_n_i, terminal_ready_out_a_n_i,
			serial_tx_b_i, request_send_out_b_n_i,
			serial_tx_a_i, terminal_ready_out_b_n_i,
			serial_rx_b_i, serial_rx_a_i,
			ring_indicate_in_b_n_i, ring_indicate_in_a_n_i,
			carrier_detect_in_b_n_i, carrier_detect_in_a_n_i,
			set_ready_in_b_n_i, set_ready_in_a_n_i,
			clear_to_send_in_b_n_i, clear_to_send_in_a_n_i}),
		.sync_o    ({strap_s, rx_s, modem_n_s})
	);

	// Strap bits in the order of the latched vector
	assign strap_sample = strap_s;

	// Port A status; bits read high when the low-active modem lines are asserted
	modem_status u_status_a (
		.clk_i        (clk_i),
		.reset_n_i    (reset_n_i),
		.enable_i     (running),
		.cts_n_i      (modem_n_s[0]),
		.dsr_n_i      (modem_n_s[2]),
		.ri_n_i       (modem_n_s[6]),
		.dcd_n_i      (modem_n_s[4]),
		.read_clear_i (status_read_a_i),
		.status_o     (handshake_status_a_o)
	);

	// Port B status
	modem_status u_status_b (
		.clk_i        (clk_i),
		.reset_n_i    (reset_n_i),
		.enable_i     (running),
		.cts_n_i      (modem_n_s[1]),
		.dsr_n_i      (modem_n_s[3]),
		.ri_n_i       (modem_n_s[7]),
		.dcd_n_i      (modem_n_s[5]),
		.read_clear_i (status_read_b_i),
		.status_o     (handshake_status_b_o)
	);

	// Strap sequencer state
	strap_state_t            state_r;
	strap_state_t            state_nxt;
	logic [CNT_W-1:0]        cnt_r;
	logic [CNT_W-1:0]        cnt_nxt;
	logic [5:0]              straps_r;
	logic [5:0]              straps_nxt;
	logic                    valid_nxt;

	assign running = (state_r == ST_RUN);

	// Pulls stay on until the pins settle; the sample is then frozen
	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		straps_nxt = straps_r;
		valid_nxt  = straps_valid_o;
		case (state_r)
			ST_PULL: begin
				if (cnt_r == SETTLE_LAST) begin
					state_nxt  = ST_RUN;
					straps_nxt = strap_sample;
					valid_nxt  = 1'b1;
				end else begin
					cnt_nxt = cnt_r + CNT_W'(1);
				end
			end
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_PULL;
				cnt_nxt   = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r        <= ST_PULL;
			cnt_r          <= '0;
			straps_r       <= `STRAP_RESET;
			straps_valid_o <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			cnt_r          <= cnt_nxt;
			straps_r       <= straps_nxt;
			straps_valid_o <= valid_nxt;
		end
	end

	// Fixed base lookups
	function automatic logic [9:0] uart_base(input addr_sel_t sel);
		case (sel)
			2'h0:    uart_base = `UART_BASE_0;
			2'h1:    uart_base = `UART_BASE_1;
			2'h2:    uart_base = `UART_BASE_2;
			default: uart_base = `UART_BASE_3;
		endcase
	endfunction

	function automatic logic [9:0] printer_base(input addr_sel_t sel);
		case (sel)
			2'h0:    printer_base = `PRINTER_BASE_0;
			2'h1:    printer_base = `PRINTER_BASE_1;
			2'h2:    printer_base = `PRINTER_BASE_2;
			default: printer_base = `PRINTER_BASE_3;
		endcase
	endfunction

	// Address selections derived from the held straps
	addr_sel_t   ua_sel_nxt;
	addr_sel_t   ub_sel_nxt;
	addr_sel_t   pr_sel_nxt;
	logic [9:0]  ua_base_nxt;
	logic [9:0]  ub_base_nxt;
	logic [9:0]  pr_base_nxt;

	always_comb begin
		ua_sel_nxt = {straps_nxt[`STRAP_UA_HI],
			straps_nxt[`STRAP_UA_LO]};
		ub_sel_nxt = {straps_nxt[`STRAP_UB_HI],
			straps_nxt[`STRAP_UB_LO]};
		pr_sel_nxt = {straps_nxt[`STRAP_PR_HI],
			straps_nxt[`STRAP_PR_LO]};
		ua_base_nxt = uart_base(ua_sel_nxt);
		ub_base_nxt = uart_base(ub_sel_nxt);
		pr_base_nxt = printer_base(pr_sel_nxt);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			uart_a_sel_o   <= 2'h0;
			uart_b_sel_o   <= 2'h0;
			printer_sel_o  <= 2'h0;
			uart_a_base_o  <= `UART_BASE_0;
			uart_b_base_o  <= `UART_BASE_0;
			printer_base_o <= `PRINTER_BASE_0;
		end else begin
			uart_a_sel_o   <= ua_sel_nxt;
			uart_b_sel_o   <= ub_sel_nxt;
			printer_sel_o  <= pr_sel_nxt;
			uart_a_base_o  <= ua_base_nxt;
			uart_b_base_o  <= ub_base_nxt;
			printer_base_o <= pr_base_nxt;
		end
	end

	// Pin drive and receive path
	logic        tx_a_nxt;
	logic        tx_b_nxt;
	logic        dtr_a_nxt;
	logic        dtr_b_nxt;
	logic        rts_a_nxt;
	logic        rts_b_nxt;
	logic        oe_n_nxt;
	logic        pull_nxt;
	logic        rx_a_nxt;
	logic        rx_b_nxt;
	logic        ir_rx_nxt;

	// Pins float with pulls on until straps are held, then drive
	always_comb begin
		tx_a_nxt  = `LINE_IDLE;
		tx_b_nxt  = `LINE_IDLE;
		dtr_a_nxt = `LINE_IDLE;
		dtr_b_nxt = `LINE_IDLE;
		rts_a_nxt = `LINE_IDLE;
		rts_b_nxt = `LINE_IDLE;
		rx_a_nxt  = `LINE_IDLE;
		rx_b_nxt  = `LINE_IDLE;
		ir_rx_nxt = `LINE_IDLE;
		oe_n_nxt  = 1'b1;
		pull_nxt  = 1'b1;
		if (valid_nxt) begin
			oe_n_nxt  = 1'b0;
			pull_nxt  = 1'b0;
			tx_a_nxt  = uart_tx_a_i;
			tx_b_nxt  = infrared_select_i ? infrared_tx_i
				: uart_tx_b_i;
			dtr_a_nxt = ~terminal_ready_a_i;
			dtr_b_nxt = ~terminal_ready_b_i;
			rts_a_nxt = ~request_send_a_i;
			rts_b_nxt = ~request_send_b_i;
			rx_a_nxt  = rx_s[0];
			// Wired receiver idles while the pin serves infrared
			rx_b_nxt  = infrared_select_i ? `LINE_IDLE : rx_s[1];
			ir_rx_nxt = infrared_select_i ? rx_s[1] : `LINE_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			serial_tx_a_o               <= `LINE_IDLE;
			serial_tx_b_o               <= `LINE_IDLE;
			terminal_ready_out_a_n_o    <= `LINE_IDLE;
			terminal_ready_out_b_n_o    <= `LINE_IDLE;
			request_send_out_a_n_o      <= `LINE_IDLE;
			request_send_out_b_n_o      <= `LINE_IDLE;
			serial_tx_a_oe_n_o          <= `PIN_OE_N_RESET;
			serial_tx_b_oe_n_o          <= `PIN_OE_N_RESET;
			terminal_ready_out_a_oe_n_o <= `PIN_OE_N_RESET;
			terminal_ready_out_b_oe_n_o <= `PIN_OE_N_RESET;
			request_send_out_a_oe_n_o   <= `PIN_OE_N_RESET;
			request_send_out_b_oe_n_o   <= `PIN_OE_N_RESET;
			strap_pull_up_o             <= 1'b1;
			strap_pull_down_o           <= 1'b1;
			uart_rx_a_o                 <= `LINE_IDLE;
			uart_rx_b_o                 <= `LINE_IDLE;
			infrared_rx_o               <= `LINE_IDLE;
		end else begin
			serial_tx_a_o               <= tx_a_nxt;
			serial_tx_b_o               <= tx_b_nxt;
			terminal_ready_out_a_n_o    <= dtr_a_nxt;
			terminal_ready_out_b_n_o    <= dtr_b_nxt;
			request_send_out_a_n_o      <= rts_a_nxt;
			request_send_out_b_n_o      <= rts_b_nxt;
			serial_tx_a_oe_n_o          <= oe_n_nxt;
			serial_tx_b_oe_n_o          <= oe_n_nxt;
			terminal_ready_out_a_oe_n_o <= oe_n_nxt;
			terminal_ready_out_b_oe_n_o <= oe_n_nxt;
			request_send_out_a_oe_n_o   <= oe_n_nxt;
			request_send_out_b_oe_n_o   <= oe_n_nxt;
			strap_pull_up_o             <= pull_nxt;
			strap_pull_down_o           <= pull_nxt;
			uart_rx_a_o                 <= rx_a_nxt;
			uart_rx_b_o                 <= rx_b_nxt;
			infrared_rx_o               <= ir_rx_nxt;
		end
	end

	// Interrupt steering
	logic        irq_pri_nxt;
	logic        irq_sec_nxt;
	logic        irq_oe_n_nxt;

	// Even select codes are the first and third COM slots
	always_comb begin
		irq_pri_nxt = (uart_irq_a_i & ~ua_sel_nxt[0])
			| (uart_irq_b_i & ~ub_sel_nxt[0]);
		irq_sec_nxt = (uart_irq_a_i & ua_sel_nxt[0])
			| (uart_irq_b_i & ub_sel_nxt[0]);
		// Floating lines let other cards share the interrupt
		irq_oe_n_nxt = ~(valid_nxt & host_irq_enable_i);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			serial_irq_primary_o        <= 1'b0;
			serial_irq_secondary_o      <= 1'b0;
			serial_irq_primary_oe_n_o   <= `PIN_OE_N_RESET;
			serial_irq_secondary_oe_n_o <= `PIN_OE_N_RESET;
		end else begin
			serial_irq_primary_o        <= irq_pri_nxt;
			serial_irq_secondary_o      <= irq_sec_nxt;
			serial_irq_primary_oe_n_o   <= irq_oe_n_nxt;
			serial_irq_secondary_oe_n_o <= irq_oe_n_nxt;
		end
	end

endmodule // serial_port_pins

// ===== design/serial_pins_params.svh
// Constants for the serial port pin, strap and modem-status block
`ifndef SERIAL_PINS_PARAMS_SVH
`define SERIAL_PINS_PARAMS_SVH

// Clock and strap settle timing
`define CLK_PERIOD_NS      40
`define STRAP_SETTLE_NS    1000
`define STRAP_SETTLE_CYC   ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Handshake status field positions
`define HS_DCTS_BIT        0
`define HS_DDSR_BIT        1
`define HS_TERI_BIT        2
`define HS_DDCD_BIT        3
`define HS_CTS_BIT         4
`define HS_DSR_BIT         5
`define HS_RI_BIT          6
`define HS_DCD_BIT         7
`define HS_RESET           8'h00

// Idle level of serial lines and pin reset values
`define LINE_IDLE          1'b1
`define PIN_OE_N_RESET     1'b1
`define STRAP_RESET        6'h00

// Strap bit positions inside the latched strap vector
`define STRAP_UA_LO        0
`define STRAP_UA_HI        1
`define STRAP_UB_LO        2
`define STRAP_UB_HI        3
`define STRAP_PR_LO        4
`define STRAP_PR_HI        5

// Base address lookup, indexed by a two-bit strap code
`define UART_BASE_0        10'h3F8
`define UART_BASE_1        10'h2F8
`define UART_BASE_2        10'h3E8
`define UART_BASE_3        10'h2E8
`define PRINTER_BASE_0     10'h378
`define PRINTER_BASE_1     10'h278
`define PRINTER_BASE_2     10'h3BC
`define PRINTER_BASE_3     10'h000

`endif

// ===== design/serial_pins_pkg.sv
// Types shared by the serial port pin block
package serial_pins_pkg;

	// Two-bit address select taken from a pair of straps
	typedef logic [1:0] addr_sel_t;

	// Power-on sequence of the shared pins
	typedef enum logic [1:0] {
		ST_PULL,
		ST_RUN
	} strap_state_t;

endpackage

// ===== design/pin_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps

module pin_sync #(
	parameter int          W         = 1,
	parameter logic        RESET_BIT = 1'b1
) (
	input  wire logic          clk_i,
	input  wire logic          reset_n_i,
	input  wire logic [W-1:0]  pins_i,
	output logic      [W-1:0]  sync_o
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_nxt;

	// First stage feeds only the second stage
	always_comb begin
		meta_nxt = pins_i;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_r <= {W{RESET_BIT}};
			sync_o <= {W{RESET_BIT}};
		end else begin
			meta_r <= meta_nxt;
			sync_o <= sync_nxt;
		end
	end

endmodule // pin_sync

// ===== design/modem_status.sv
// Handshake status of one port: line levels and sticky change flags
`timescale 1ns/10ps
`include "serial_pins_params.svh"

module modem_status (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        enable_i,
	input  wire logic        cts_n_i,
	input  wire logic        dsr_n_i,
	input  wire logic        ri_n_i,
	input  wire logic        dcd_n_i,
	input  wire logic        read_clear_i,
	output logic      [7:0]  status_o
);

	logic [3:0] level;
	logic [3:0] prev_r;
	logic [3:0] prev_nxt;
	logic [3:0] delta_old;
	logic [3:0] change;
	logic [7:0] status_nxt;

	// Pins are active low; status bits read high when asserted
	assign level = {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};

	// Change flags: a new event beats a clear in the same cycle
	always_comb begin
		delta_old = status_o[3:0];
		change    = 4'h0;
		if (enable_i) begin
			change[`HS_DCTS_BIT] = level[0] ^ prev_r[0];
			change[`HS_DDSR_BIT] = level[1] ^ prev_r[1];
			change[`HS_TERI_BIT] = prev_r[2] & ~level[2]; // Ring ended
			change[`HS_DDCD_BIT] = level[3] ^ prev_r[3];
		end
		if (read_clear_i) begin
			delta_old = 4'h0;
		end
		prev_nxt   = enable_i ? level : prev_r;
		status_nxt = {level, delta_old | change};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prev_r   <= 4'h0;
			status_o <= `HS_RESET;
		end else begin
			prev_r   <= prev_nxt;
			status_o <= status_nxt;
		end
	end

endmodule // modem_status

// ===== testbench/pins_chk.sv
// Port-level assertions for the serial pin and strap block
`timescale 1ns/10ps

module pins_chk (
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       clear_to_send_in_a_n_i,
	input wire logic       serial_rx_a_i,
	input wire logic       serial_tx_a_i,
	input wire logic       terminal_ready_out_b_n_i,
	input wire logic       serial_tx_a_o,
	input wire logic       serial_tx_b_o,
	input wire logic       serial_tx_a_oe_n_o,
	input wire logic       terminal_ready_out_a_n_o,
	input wire logic       request_send_out_b_n_o,
	input wire logic       strap_pull_up_o,
	input wire logic       strap_pull_down_o,
	input wire logic       serial_irq_primary_o,
	input wire logic       serial_irq_primary_oe_n_o,
	input wire logic       serial_irq_secondary_oe_n_o,
	input wire logic       uart_tx_a_i,
	input wire logic       uart_tx_b_i,
	input wire logic       infrared_tx_i,
	input wire logic       terminal_ready_a_i,
	input wire logic       request_send_b_i,
	input wire logic       uart_irq_a_i,
	input wire logic       uart_irq_b_i,
	input wire logic       infrared_select_i,
	input wire logic       host_irq_enable_i,
	input wire logic       uart_rx_a_o,
	input wire logic [7:0] handshake_status_a_o,
	input wire logic       straps_valid_o,
	input wire logic [1:0] uart_a_sel_o,
	input wire logic [1:0] uart_b_sel_o,
	input wire logic [1:0] printer_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Two sync flops, then a register
	cts_level_a: assert property (
		$past(straps_valid_o, 3) |-> handshake_status_a_o[4] ==
		!$past(clear_to_send_in_a_n_i, 3)) else $error("cts bit wrong");
	rx_a_path_a: assert property (
		$past(straps_valid_o, 3) |-> uart_rx_a_o ==
		$past(serial_rx_a_i, 3)) else $error("rx a wrong");
	tx_a_path_a: assert property (
		$past(straps_valid_o) |-> serial_tx_a_o == $past(uart_tx_a_i)
		&& !serial_tx_a_oe_n_o) else $error("tx a wrong");
	// Select picks infrared or wired data for port B
	tx_b_path_a: assert property (
		$past(straps_valid_o) |-> serial_tx_b_o ==
		($past(infrared_select_i) ? $past(infrared_tx_i) :
		$past(uart_tx_b_i))) else $error("tx b wrong");
	line_drive_a: assert property (
		$past(straps_valid_o) |->
		terminal_ready_out_a_n_o == !$past(terminal_ready_a_i) &&
		request_send_out_b_n_o == !$past(request_send_b_i))
		else $error("modem out wrong");
	float_pre_a: assert property (
		!straps_valid_o |-> serial_tx_a_oe_n_o && strap_pull_up_o &&
		strap_pull_down_o && serial_irq_primary_oe_n_o)
		else $error("pins not released");
	// Strap sample is the pin three sampled edges back
	strap_latch_a: assert property (
		$rose(straps_valid_o) |->
		uart_a_sel_o[1] == $past(serial_tx_a_i, 3) &&
		uart_a_sel_o[0] == $past(terminal_ready_out_b_n_i, 3))
		else $error("strap latch wrong");
	strap_hold_a: assert property (
		$past(straps_valid_o) |-> $stable(uart_a_sel_o) &&
		$stable(uart_b_sel_o) && $stable(printer_sel_o))
		else $error("straps changed");
	irq_float_a: assert property (
		!$past(host_irq_enable_i) |-> serial_irq_primary_oe_n_o &&
		serial_irq_secondary_oe_n_o) else $error("irq not floating");
	irq_route_a: assert property (
		$past(straps_valid_o) && $past(host_irq_enable_i) |->
		serial_irq_primary_o ==
		($past(uart_irq_a_i) && !uart_a_sel_o[0] ||
		$past(uart_irq_b_i) && !uart_b_sel_o[0]))
		else $error("irq route wrong");
endmodule // pins_chk

bind serial_port_pins pins_chk chk (.*);

// ===== testbench/modem_far_end.sv
// Far-end model: port A modem, receive lines and board strap resistors
`timescale 1ns/10ps

module modem_far_end (
	input  wire logic [3:0] assert_i,
	input  wire logic [1:0] rx_i,
	input  wire logic [5:0] strap_i,
	input  wire logic [5:0] strap_en_i,
	input  wire logic [5:0] pin_o_i,
	input  wire logic [5:0] pin_oe_n_i,
	input  wire logic       pull_up_i,
	input  wire logic       pull_down_i,
	output logic      [3:0] modem_a_n_o,
	output logic      [3:0] modem_b_n_o,
	output logic      [1:0] rx_o,
	output logic      [5:0] pin_lvl_o
);
	// Pulled up: serial out A and B, request-to-send A
	localparam logic [5:0] PULL_UP = 6'h13;

	// Asserted lines go low; {carrier, ring, set-ready, clear-to-send}
	assign modem_a_n_o = ~assert_i;
	assign modem_b_n_o = 4'hF;
	assign rx_o = rx_i;

	// Device drive beats strap resistor, which beats the weak pull
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			if (!pin_oe_n_i[k])
				pin_lvl_o[k] = pin_o_i[k];
			else if (strap_en_i[k])
				pin_lvl_o[k] = strap_i[k];
			else if (PULL_UP[k] ? pull_up_i : pull_down_i)
				pin_lvl_o[k] = PULL_UP[k];
			else
				pin_lvl_o[k] = ~pin_o_i[k]; // Float: inverse
		end
	end
endmodule // modem_far_end

// ===== testbench/serial_port_pins_and_straps_test.sv
// Self-checking bench for the serial pin and strap block
`timescale 1ns/10ps

module serial_port_pins_and_straps_test;
	import serial_pins_pkg::*;
	localparam int SETTLE = 6;
	localparam logic [5:0] PULL_UP = 6'h13;
	logic clk_i = 0, reset_n_i = 0, pu, pd, irq_p, irq_po, irq_s, irq_so;
	logic [3:0] mdm = 0, ma_n, mb_n;
	logic [1:0] rx = 2'h3, rxl;
	logic [5:0] strap = 0, strap_en = 0, po, poe, lvl, e;
	logic utx_a = 1, utx_b = 1, irtx = 1, ir_sel = 0, tr_a = 0, tr_b = 0;
	logic rs_a = 0, rs_b = 0, irq_a = 0, irq_b = 0, hen = 0, rd_a = 0;
	logic rd_b = 0, rx_a_o, rx_b_o, ir_rx, valid;
	logic [7:0] st_a, st_b;
	addr_sel_t sel_a, sel_b, sel_p;
	logic [9:0] base_a, base_b, base_p;
	int n_mismatch = 0, samples_checked = 0, seed;

	always #20 clk_i = ~clk_i;

	modem_far_end far (.assert_i(mdm), .rx_i(rx), .strap_i(strap),
		.strap_en_i(strap_en), .pin_o_i(po), .pin_oe_n_i(poe),
		.pull_up_i(pu), .pull_down_i(pd), .modem_a_n_o(ma_n),
		.modem_b_n_o(mb_n), .rx_o(rxl), .pin_lvl_o(lvl));

	serial_port_pins #(.SETTLE_CYC(SETTLE)) dut (.clk_i, .reset_n_i,
		.clear_to_send_in_a_n_i(ma_n[0]), .clear_to_send_in_b_n_i(mb_n[0]),
		.set_ready_in_a_n_i(ma_n[1]), .set_ready_in_b_n_i(mb_n[1]),
		.ring_indicate_in_a_n_i(ma_n[2]), .ring_indicate_in_b_n_i(mb_n[2]),
		.carrier_detect_in_a_n_i(ma_n[3]),
		.carrier_detect_in_b_n_i(mb_n[3]),
		.serial_rx_a_i(rxl[0]), .serial_rx_b_i(rxl[1]),
		.serial_tx_a_i(lvl[0]), .serial_tx_a_o(po[0]),
		.serial_tx_a_oe_n_o(poe[0]), .serial_tx_b_i(lvl[1]),
		.serial_tx_b_o(po[1]), .serial_tx_b_oe_n_o(poe[1]),
		.terminal_ready_out_a_n_i(lvl[2]), .terminal_ready_out_a_n_o(po[2]),
		.terminal_ready_out_a_oe_n_o(poe[2]),
		.terminal_ready_out_b_n_i(lvl[3]), .terminal_ready_out_b_n_o(po[3]),
		.terminal_ready_out_b_oe_n_o(poe[3]),
		.request_send_out_a_n_i(lvl[4]), .request_send_out_a_n_o(po[4]),
		.request_send_out_a_oe_n_o(poe[4]),
		.request_send_out_b_n_i(lvl[5]), .request_send_out_b_n_o(po[5]),
		.request_send_out_b_oe_n_o(poe[5]),
		.strap_pull_up_o(pu), .strap_pull_down_o(pd),
		.serial_irq_primary_o(irq_p), .serial_irq_primary_oe_n_o(irq_po),
		.serial_irq_secondary_o(irq_s),
		.serial_irq_secondary_oe_n_o(irq_so),
		.uart_tx_a_i(utx_a), .uart_tx_b_i(utx_b), .infrared_tx_i(irtx),
		.terminal_ready_a_i(tr_a), .terminal_ready_b_i(tr_b),
		.request_send_a_i(rs_a), .request_send_b_i(rs_b),
		.uart_irq_a_i(irq_a), .uart_irq_b_i(irq_b),
		.infrared_select_i(ir_sel), .host_irq_enable_i(hen),
		.status_read_a_i(rd_a), .status_read_b_i(rd_b),
		.uart_rx_a_o(rx_a_o), .uart_rx_b_o(rx_b_o), .infrared_rx_o(ir_rx),
		.handshake_status_a_o(st_a), .handshake_status_b_o(st_b),
		.straps_valid_o(valid), .uart_a_sel_o(sel_a), .uart_b_sel_o(sel_b),
		.printer_sel_o(sel_p), .uart_a_base_o(base_a),
		.uart_b_base_o(base_b), .printer_base_o(base_p));

	// Expected base lookups
	function automatic logic [9:0] ubase(input logic [1:0] c);
		return c[1] ? (c[0] ? 10'h2E8 : 10'h3E8) : (c[0] ? 10'h2F8 : 10'h3F8);
	endfunction
	function automatic logic [9:0] pbase(input logic [1:0] c);
		return c[1] ? (c[0] ? 10'h000 : 10'h3BC) : (c[0] ? 10'h278 : 10'h378);
	endfunction

	task automatic check_vec(input string nm, input logic [9:0] x,
		input logic [9:0] g);
		samples_checked++;
		if (g !== x) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Reset, then time the strap latch
	task automatic do_reset;
		int n;
		@(negedge clk_i);
		reset_n_i = 0;
		repeat (16) @(negedge clk_i);
		check_vec("float", 10'h03F, 10'(poe));
		reset_n_i = 1;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (valid !== 1'b1 && n < 100);
		if (n >= 100) begin
			n_mismatch++;
			report_and_stop;
		end
		check_vec("settle", 10'(SETTLE), 10'(n));
	endtask

	task automatic check_straps;
		for (int k = 0; k < 6; k++)
			e[k] = strap_en[k] ? strap[k] : PULL_UP[k];
		check_vec("sel_a", 10'({e[0], e[3]}), 10'(sel_a));
		check_vec("sel_b", 10'({e[1], e[5]}), 10'(sel_b));
		check_vec("sel_p", 10'({e[4], e[2]}), 10'(sel_p));
		check_vec("base_a", ubase({e[0], e[3]}), base_a);
		check_vec("base_b", ubase({e[1], e[5]}), base_b);
		check_vec("base_p", pbase({e[4], e[2]}), base_p);
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		report_and_stop;
	end

	initial begin
		seed = 32'h1E1D78FC;
		for (int it = 0; it < 4; it++) begin
			strap_en = (it == 0) ? 6'h00 : 6'h3F;
			strap = (it < 2) ? 6'h00 : (it == 2) ? 6'h3F : 6'($random(seed));
			do_reset;
			check_straps;
			// Random core traffic
			repeat (24) begin
				@(negedge clk_i);
				{utx_a, utx_b, irtx, ir_sel, tr_a, tr_b, rs_a, rs_b} =
					8'($random(seed));
				@(negedge clk_i);
				check_vec("tx", {8'h00, ir_sel ? irtx : utx_b, utx_a},
					10'(po[1:0]));
				check_vec("mdm_out", {6'h00, ~rs_b, ~rs_a, ~tr_b, ~tr_a},
					10'(po[5:2]));
				check_vec("oe_n", 10'h000, 10'(poe));
			end
			check_straps;
			$display("strap round %0d done", it);
		end
		// Port A modem lines on, then off
		ir_sel = 0;
		mdm = 4'hF;
		repeat (4) @(negedge clk_i);
		check_vec("status_a", 10'h0FB, 10'(st_a));
		rd_a = 1;
		@(negedge clk_i);
		rd_a = 0;
		check_vec("status_clr", 10'h0F0, 10'(st_a));
		mdm = 4'h0;
		repeat (4) @(negedge clk_i);
		check_vec("status_off", 10'h00F, 10'(st_a));
		check_vec("status_b", 10'h000, 10'(st_b));
		$display("modem test done");
		// Receive routing, infrared on and off
		rx = 2'h0;
		ir_sel = 1;
		repeat (4) @(negedge clk_i);
		check_vec("rx_ir", 10'h002, {7'h00, ir_rx, rx_b_o, rx_a_o});
		ir_sel = 0;
		repeat (4) @(negedge clk_i);
		check_vec("rx_wire", 10'h004, {7'h00, ir_rx, rx_b_o, rx_a_o});
		rx = 2'h3;
		$display("receive test done");
		// Interrupt float and routing
		irq_a = 1;
		repeat (2) @(negedge clk_i);
		check_vec("irq_off", 10'h003, {8'h00, irq_so, irq_po});
		hen = 1;
		repeat (2) @(negedge clk_i);
		check_vec("irq_a", {6'h00, e[3], ~e[3], 2'b00},
			{6'h00, irq_s, irq_p, irq_so, irq_po});
		irq_a = 0;
		irq_b = 1;
		repeat (2) @(negedge clk_i);
		check_vec("irq_b", {8'h00, e[5], ~e[5]}, {8'h00, irq_s, irq_p});
		$display("interrupt test done");
		report_and_stop;
	end
endmodule // serial_port_pins_and_straps_test
